// ===== reset_source_control_consts.svh
// reset source control: timing counts, apb offsets, field positions
// assumes a 25 mhz pclk; included by the package and the design
`ifndef RESET_SOURCE_CONTROL_CONSTS_SVH
`define RESET_SOURCE_CONTROL_CONSTS_SVH

`define CLK_PERIOD_NS        40
`define POWERUP_TIMEOUT_MS   64
`define POWERUP_CYCLES       ((`POWERUP_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define FILTER_TIME_NS       400
`define FILTER_CYCLES        ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_FILTER_NS        200
`define PIN_FILTER_CYCLES    ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXEC_DELAY_CYCLES    10
`define CNT_W                21

`define ADDR_CTRL            12'h000
`define ADDR_CAUSE           12'h004
`define ADDR_STAT            12'h008

`define CTRL_SW_EN_BIT       0
`define CTRL_PULLUP_BIT      1
`define CTRL_RESET           2'h1
`define CAUSE_W              8
`define CAUSE_RESET          8'hff

`endif

// ===== reset_source_control_pkg.sv
// reset source control: types shared by the design and its bench
// assumes the consts header sits in the same folder
package reset_source_control_pkg;
   `include "reset_source_control_consts.svh"

   typedef enum logic [1:0] {
      brownout_off   = 2'b00,
      brownout_sw    = 2'b01,
      brownout_nslp  = 2'b10,
      brownout_on    = 2'b11
   } brownout_mode_t;

   typedef enum logic [2:0] {
      st_hold   = 3'b000,
      st_powerup = 3'b001,
      st_pin    = 3'b010,
      st_exec   = 3'b011,
      st_run    = 3'b100
   } seq_state_t;

   // cause flags as in the cause register: active low, except the two stack flags, which are set to 1
   typedef struct packed {
      logic stk_ovf_n;
      logic stk_unf_n;
      logic wdog_n;
      logic pin_n;
      logic instr_n;
      logic por_n;
      logic bor_n;
      logic prog_n;
   } cause_t;

   typedef struct packed {
      brownout_mode_t brownout_mode_cfg;
      logic [1:0] brownout_level_sel;
      logic       reset_pin_enable_cfg;
      logic       low_voltage_prog_cfg;
      logic [1:0] powerup_delay_select;
   } cfg_t;

   typedef struct packed {
      logic s1_por;
      logic s2_por;
      logic s1_low;
      logic s2_low;
      logic s1_rdy;
      logic s2_rdy;
      logic s1_pin;
      logic s2_pin;
   } sync_t;

   typedef struct packed {
      sync_t                     sy;
      seq_state_t                st;
      logic [`CNT_W-1:0]         cnt;
      logic [3:0]                brownout_cnt;
      logic [3:0]                pin_cnt;
      logic                      pin_filt;
      logic                      sw_en;
      logic                      pullup_sw;
      cause_t                    cause;
      logic                      core_rst;
      logic                      exec_en;
      logic [31:0]               prdata;
   } state_t;
endpackage

// ===== reset_source_control.sv
// reset source control: gathers reset sources, runs start-up sequence
// assumes analog monitor outputs and the pin are async; apb on pclk
// How it works
// R1: power-on, brown-out, pin, watchdog, instruction, stack, prog-exit all reset
// R2: power-up delay timer extends reset after power-on or brown-out
// R3: reset held while power-on monitor reports low supply
// R4: programming exit runs the power-on sequence and flags
// R5: 2-bit mode picks always on, off in sleep, software, always off
// R6: threshold select passed straight to the supply monitor
// R7: brown-out resets only after low persists past filter time
// R8: always on: start waits for ready, active in sleep, no wake delay
// R9: off in sleep: inactive asleep, wake waits for monitor ready
// R10: software mode: enable bit decides, start-up does not wait
// R11: software mode: active once ready, ready flag readable, sleep ignored
// R12: always off: detection off, software enable ignored
// R13: always on: ready flag set before core may execute
// R14: pin function on when low-voltage prog is 1 or pin enable is 1
// R15: pin reset clears the pin cause flag
// R16: enabled pin held low keeps device in reset
// R17: short pin pulses are filtered out
// R18: pin never driven low by internal resets
// R19: enabled pin function forces the weak pull-up
// R20: disabled pin is plain input, pull-up under software
// R21: power-up timer starts at release, holds up to its time-out
// R22: execution begins fixed clock count after reset release
// R23: each reset but power-on updates only its own cause flag; power-on sets all others to 1
// R24: resets merged, asserted async and released on pclk; only presetn asserts async, the other sources assert on pclk through core_rst
// R25: pin and monitor outputs synchronised before use
`timescale 1ns/1ns
`include "reset_source_control_consts.svh"
module reset_source_control
   import reset_source_control_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // configuration bits
   input  wire cfg_t        cfg,
   // analog monitors
   input  wire logic        por_low,
   input  wire logic        brownout_low,
   input  wire logic        brownout_ready,
   output logic [1:0]       brownout_level_sel,
   output logic             brownout_monitor_en,
   // external reset pin and its pad
   input  wire logic        external_reset_pin,
   output logic             pin_out,
   output logic             pin_oe_n,
   output logic             pin_pullup_en,
   output logic             pin_gpio_in,
   // core side reset requests, sleep state and wake request
   input  wire logic        watchdog_reset,
   input  wire logic        reset_instr,
   input  wire logic        stack_overflow_reset,
   input  wire logic        stack_underflow_reset,
   input  wire logic        prog_exit,
   input  wire logic        sleep_mode,
   input  wire logic        wake_req,
   // core side results
   output logic             core_reset_n,
   output logic             exec_enable,
   output logic             wake_hold
);
   state_t r_r;
   state_t r_nxt;

   logic pin_fn;
   logic brownout_active;
   logic brownout_trip;
   logic pin_rst;
   logic core_req;
   logic por_req;
   logic wr;
   logic rd;
   logic start_wait;
   logic powerup_on;
   logic [`CNT_W-1:0] powerup_len;

   assign pin_fn = cfg.low_voltage_prog_cfg
                 | cfg.reset_pin_enable_cfg; // R14
   always_comb begin
      case (cfg.brownout_mode_cfg) // R5
         brownout_on:   brownout_active = 1'b1; // R8
         brownout_nslp: brownout_active = ~sleep_mode; // R9
         brownout_sw:   brownout_active = r_r.sw_en & r_r.sy.s2_rdy; // R10 R11
         default:       brownout_active = 1'b0; // R12
      endcase
   end
   // monitor kept alive in sw mode regardless of sleep
   assign brownout_monitor_en = brownout_active
      | (cfg.brownout_mode_cfg == brownout_sw && r_r.sw_en); // R11
   assign brownout_level_sel = cfg.brownout_level_sel; // R6
   assign brownout_trip = brownout_active
      && r_r.brownout_cnt >= 4'(`FILTER_CYCLES); // R7
   assign pin_rst  = pin_fn & ~r_r.pin_filt; // R16
   assign por_req  = r_r.sy.s2_por | prog_exit; // R3 R4
   assign core_req = watchdog_reset | reset_instr
      | stack_overflow_reset | stack_underflow_reset; // R1
   assign start_wait = (cfg.brownout_mode_cfg == brownout_on
      || cfg.brownout_mode_cfg == brownout_nslp)
      && !(r_r.sy.s2_rdy && !r_r.sy.s2_low); // R8 R13
   assign powerup_on = cfg.powerup_delay_select != 2'b00; // R2
   always_comb begin
      case (cfg.powerup_delay_select)
         2'b01:   powerup_len = `CNT_W'(`POWERUP_CYCLES / 16);
         2'b10:   powerup_len = `CNT_W'(`POWERUP_CYCLES / 4);
         default: powerup_len = `CNT_W'(`POWERUP_CYCLES); // R21
      endcase
   end
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;

   always_comb begin
      r_nxt = r_r;
      // two-stage synchronisers, second stage only is read
      r_nxt.sy.s1_por = por_low; // R25
      r_nxt.sy.s2_por = r_r.sy.s1_por;
      r_nxt.sy.s1_low = brownout_low;
      r_nxt.sy.s2_low = r_r.sy.s1_low;
      r_nxt.sy.s1_rdy = brownout_ready;
      r_nxt.sy.s2_rdy = r_r.sy.s1_rdy;
      r_nxt.sy.s1_pin = external_reset_pin;
      r_nxt.sy.s2_pin = r_r.sy.s1_pin;

      // low supply must persist before a trip
      if (r_r.sy.s2_low && brownout_active) begin
         if (r_r.brownout_cnt != 4'hf)
            r_nxt.brownout_cnt = r_r.brownout_cnt + 4'h1; // R7
      end else begin
         r_nxt.brownout_cnt = 4'h0;
      end

      // pin filter: level must differ for several cycles to change
      if (r_r.sy.s2_pin != r_r.pin_filt) begin
         r_nxt.pin_cnt = r_r.pin_cnt + 4'h1;
         if (r_r.pin_cnt >= 4'(`PIN_FILTER_CYCLES - 1)) begin
            r_nxt.pin_filt = r_r.sy.s2_pin; // R17
            r_nxt.pin_cnt  = 4'h0;
         end
      end else begin
         r_nxt.pin_cnt = 4'h0;
      end

      // sequencer
      case (r_r.st)
         st_hold: begin
            r_nxt.core_rst = 1'b1;
            r_nxt.exec_en  = 1'b0;
            r_nxt.cnt      = '0;
            if (!por_req && !brownout_trip)
               r_nxt.st = powerup_on ? st_powerup : st_pin; // R21
         end
         st_powerup: begin
            r_nxt.cnt = r_r.cnt + `CNT_W'(1);
            if (r_r.cnt >= powerup_len - `CNT_W'(1)) begin
               r_nxt.st  = st_pin; // R2
               r_nxt.cnt = '0;
            end
         end
         st_pin: begin
            // timer runs on independently of a held pin
            if (!pin_rst && !start_wait) begin
               r_nxt.core_rst = 1'b0; // R24
               r_nxt.st       = st_exec;
               r_nxt.cnt      = '0;
            end
         end
         st_exec: begin
            r_nxt.cnt = r_r.cnt + `CNT_W'(1);
            if (r_r.cnt >= `CNT_W'(`EXEC_DELAY_CYCLES - 1)) begin
               r_nxt.exec_en = 1'b1; // R22
               r_nxt.st      = st_run;
            end
         end
         st_run: begin
            if (core_req || pin_rst) begin
               r_nxt.core_rst = 1'b1;
               r_nxt.exec_en  = 1'b0;
               r_nxt.st       = st_pin;
            end
         end
         default: r_nxt.st = st_hold;
      endcase

      // software writes first so a hardware event wins
      if (wr && paddr == `ADDR_CTRL) begin
         r_nxt.sw_en     = pwdata[`CTRL_SW_EN_BIT];
         r_nxt.pullup_sw = pwdata[`CTRL_PULLUP_BIT];
      end
      if (wr && paddr == `ADDR_CAUSE)
         r_nxt.cause = cause_t'(pwdata[`CAUSE_W-1:0]);

      // cause flags: power-on resets all flags, otherwise only the active source changes
      if (por_req) begin
         r_nxt.cause  = cause_t'(`CAUSE_RESET); // R4
         r_nxt.cause.por_n = 1'b0;
         r_nxt.st     = st_hold;
         r_nxt.sw_en  = 1'b1;
      end else if (brownout_trip) begin
         r_nxt.cause.bor_n = 1'b0; // R7 R23
         r_nxt.st     = st_hold;
         r_nxt.sw_en  = 1'b1;
      end else if (r_r.st == st_run || r_r.st == st_exec) begin
         if (pin_rst)
            r_nxt.cause.pin_n = 1'b0; // R15 R23
         if (watchdog_reset)
            r_nxt.cause.wdog_n = 1'b0; // R23
         if (reset_instr)
            r_nxt.cause.instr_n = 1'b0; // R23
         if (stack_overflow_reset)
            r_nxt.cause.stk_ovf_n = 1'b1; // R23
         if (stack_underflow_reset)
            r_nxt.cause.stk_unf_n = 1'b1; // R23
         if ((pin_rst || core_req) && r_r.st == st_exec) begin
            r_nxt.core_rst = 1'b1;
            r_nxt.exec_en  = 1'b0;
            r_nxt.st       = st_pin;
         end
      end

      // apb read data latched in setup
      if (rd) begin
         case (paddr)
            `ADDR_CTRL:  r_nxt.prdata = {30'h0, r_r.pullup_sw, r_r.sw_en};
            `ADDR_CAUSE: r_nxt.prdata = {24'h0, r_r.cause};
            `ADDR_STAT:  r_nxt.prdata = {27'h0, r_r.exec_en, pin_fn,
                                         brownout_active, r_r.pin_filt,
                                         r_r.sy.s2_rdy}; // R11 R13
            default:     r_nxt.prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r           <= '0;
         r_r.st        <= st_hold;
         r_r.core_rst  <= 1'b1;
         r_r.sw_en     <= 1'b1;
         r_r.pin_filt  <= 1'b1;
         r_r.sy.s1_pin <= 1'b1;
         r_r.sy.s2_pin <= 1'b1;
         r_r.sy.s1_por <= 1'b1;
         r_r.sy.s2_por <= 1'b1;
         r_r.cause     <= cause_t'(`CAUSE_RESET);
      end else begin
         r_r <= r_nxt;
      end
   end

   // async assert by presetn, sync release through core_rst
   assign core_reset_n  = presetn & ~r_r.core_rst; // R24
   assign exec_enable   = r_r.exec_en;
   // wake waits for ready and a supply back above threshold
   assign wake_hold     = wake_req
      && cfg.brownout_mode_cfg == brownout_nslp
      && !(r_r.sy.s2_rdy && !r_r.sy.s2_low); // R9 R8
   assign pin_out       = 1'b1; // R18
   assign pin_oe_n      = 1'b1; // R18
   assign pin_pullup_en = pin_fn | r_r.pullup_sw; // R19 R20
   assign pin_gpio_in   = r_r.sy.s2_pin; // R20
   assign prdata        = r_r.prdata;
   assign pready        = 1'b1;
   assign pslverr       = psel & penable & (paddr != `ADDR_CTRL)
      & (paddr != `ADDR_CAUSE) & (paddr != `ADDR_STAT);
endmodule // reset_source_control

// ===== rsc_properties.sv
// checker: port relations of the reset source control block
// assumes it is bound to the design module itself
`timescale 1ns/1ns
module rsc_properties
   import reset_source_control_pkg::*;
(
   // clock and reset
   input logic       pclk,
   input logic       presetn,
   // watched ports
   input cfg_t       cfg,
   input logic       por_low,
   input logic       brownout_ready,
   input logic       external_reset_pin,
   input logic       sleep_mode,
   input logic [1:0] brownout_level_sel,
   input logic       brownout_monitor_en,
   input logic       pin_oe_n,
   input logic       pin_pullup_en,
   input logic       core_reset_n,
   input logic       exec_enable,
   input logic       wake_hold,
   input logic       pslverr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic pin_fn;
   assign pin_fn = cfg.low_voltage_prog_cfg | cfg.reset_pin_enable_cfg;
   chk_pin_undriven: assert property (pin_oe_n)
      else $error("reset pin enabled as output");
   chk_level_pass: assert property (
      brownout_level_sel == cfg.brownout_level_sel)
      else $error("threshold select not passed on");
   chk_pullup_forced: assert property (pin_fn |-> pin_pullup_en)
      else $error("pull-up off while pin function on");
   chk_por_hold: assert property (por_low [*4] |-> !core_reset_n)
      else $error("core out of reset during low supply");
   chk_pin_hold: assert property (
      (pin_fn && !external_reset_pin) [*8] |-> ##[0:2] !core_reset_n)
      else $error("held pin did not reset core");
   chk_exec_delay: assert property (
      $rose(core_reset_n) |-> !exec_enable ##[8:11] exec_enable)
      else $error("execution delay wrong");
   chk_brownout_off: assert property (
      cfg.brownout_mode_cfg == brownout_off |-> !brownout_monitor_en)
      else $error("monitor on in always-off mode");
   chk_brownout_on: assert property (
      cfg.brownout_mode_cfg == brownout_on
      |-> brownout_monitor_en && !wake_hold)
      else $error("always-on mode not active or wake held");
   chk_sleep_off: assert property (
      cfg.brownout_mode_cfg == brownout_nslp && sleep_mode
      |-> !brownout_monitor_en)
      else $error("monitor on during sleep");
   chk_ready_first: assert property (
      cfg.brownout_mode_cfg == brownout_on && $rose(exec_enable)
      |-> brownout_ready)
      else $error("execution before monitor ready");
   cover property ($rose(core_reset_n));
   cover property ($fell(core_reset_n) && !external_reset_pin);
   cover property (pslverr);
endmodule // rsc_properties

bind reset_source_control rsc_properties u_rsc_properties (.pclk,
   .presetn, .cfg, .por_low, .brownout_ready, .external_reset_pin,
   .sleep_mode, .brownout_level_sel, .brownout_monitor_en, .pin_oe_n,
   .pin_pullup_en,
   .core_reset_n, .exec_enable, .wake_hold, .pslverr);

// ===== supply_pin_model.sv
// model: supply monitors and the reset pin with its weak pull-up
// assumes one bench process calls its tasks just after a pclk edge
`timescale 1ns/1ns
module supply_pin_model #(parameter int READY_DLY = 6) (
   // clock
   input  wire logic pclk,
   // monitor outputs and pin level
   output logic      por_low,
   output logic      brownout_low,
   output logic      brownout_ready,
   output logic      external_reset_pin
);
   initial begin
      por_low = 1'b1;
      brownout_low = 1'b0;
      brownout_ready = 1'b0;
      external_reset_pin = 1'b1;
   end
   // ready lags the supply, so start-up gating is exercised
   task automatic power_up();
      por_low <= 1'b1;
      brownout_ready <= 1'b0;
      repeat (4) @(posedge pclk);
      por_low <= 1'b0;
      repeat (READY_DLY) @(posedge pclk);
      brownout_ready <= 1'b1;
   endtask
   // only the dipped signal is released, so dips may follow at once
   task automatic dip(input bit pin, input int n);
      if (pin) begin
         external_reset_pin <= 1'b0;
      end else begin
         brownout_low <= 1'b1;
      end
      repeat (n) @(posedge pclk);
      if (pin) begin
         external_reset_pin <= 1'b1; // released: pull-up takes it high
      end else begin
         brownout_low <= 1'b0;
      end
   endtask
endmodule // supply_pin_model

// ===== tb_top.sv
// bench: apb, config and core requests; cause flags and reset counts
// assumes power-up delay select 00, so start-up stays short
`timescale 1ns/1ns
module tb_top;
   import reset_source_control_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        por_low, brownout_low, brownout_ready, external_reset_pin;
   logic [1:0]  brownout_level_sel;
   logic        brownout_monitor_en, pin_out, pin_oe_n, pin_pullup_en;
   logic        pin_gpio_in, sleep_mode, wake_req;
   logic        core_reset_n, exec_enable, wake_hold;
   logic [4:0]  req;
   logic [7:0]  pre [5] = '{8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff};
   logic [7:0]  exp [5] = '{8'hdf, 8'hf7, 8'hbf, 8'h7f, 8'hfb};
   cfg_t        cfg;
   int          err_count, check_count, cyc, rst_cnt, n0;
   reset_source_control u_reset_source_control (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cfg,
      .por_low, .brownout_low, .brownout_ready, .brownout_level_sel,
      .brownout_monitor_en,
      .external_reset_pin, .pin_out, .pin_oe_n, .pin_pullup_en,
      .pin_gpio_in, .watchdog_reset(req[0]), .reset_instr(req[1]),
      .stack_overflow_reset(req[2]), .stack_underflow_reset(req[3]),
      .prog_exit(req[4]), .sleep_mode, .wake_req, .core_reset_n,
      .exec_enable, .wake_hold);
   supply_pin_model u_supply_pin_model (.pclk, .por_low, .brownout_low,
      .brownout_ready, .external_reset_pin);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (core_reset_n === 1'b0) rst_cnt <= rst_cnt + 1;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_run();
      repeat (3) @(posedge pclk);
      for (int n = 0; n < 300 && exec_enable !== 1'b1; n++) @(posedge pclk);
      chk("exec_enable", 1, exec_enable);
   endtask
   task automatic restart(input cfg_t c);
      presetn <= 1'b0;
      cfg <= c;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      u_supply_pin_model.power_up();
      wait_run();
   endtask
   task automatic cause(input logic [7:0] e);
      apb(0, 12'h004, 0);
      chk("cause", {24'h0, e}, rd);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, req} = '0;
      {sleep_mode, wake_req, cyc, rst_cnt} = '0;
      presetn = 1'b0;
      restart('{brownout_on, 2'h2, 1'b0, 1'b1, 2'h0});
      cause(8'hfb);
      apb(0, 12'h000, 0);
      chk("ctrl", 32'h1, rd);
      apb(0, 12'h00c, 0);
      chk("slverr", 1, er);
      for (int i = 0; i < 5; i++) begin
         apb(1, 12'h004, {24'h0, pre[i]});
         req[i] <= 1'b1;
         @(posedge pclk);
         req[i] <= 1'b0;
         wait_run();
         cause(exp[i]);
      end
      $display("sources done");
      n0 = rst_cnt;
      u_supply_pin_model.dip(1, 3);
      u_supply_pin_model.dip(0, 5);
      repeat (12) @(posedge pclk);
      chk("short pulses", n0, rst_cnt);
      apb(1, 12'h004, 32'hff);
      u_supply_pin_model.dip(1, 10);
      wait_run();
      cause(8'hef);
      chk("pin drive", 2'b11, {pin_out, pin_oe_n});
      apb(1, 12'h004, 32'hff);
      u_supply_pin_model.dip(0, 15);
      wait_run();
      cause(8'hfd);
      $display("pin and dip done");
      restart('{brownout_sw, 2'h3, 1'b1, 1'b0, 2'h0});
      chk("pullup", 1, pin_pullup_en);
      apb(1, 12'h000, 32'h0);
      n0 = rst_cnt;
      u_supply_pin_model.dip(0, 15);
      repeat (6) @(posedge pclk);
      chk("sw off", n0, rst_cnt);
      apb(1, 12'h000, 32'h1);
      u_supply_pin_model.dip(0, 15);
      wait_run();
      cause(8'hf9);
      restart('{brownout_off, 2'h1, 1'b0, 1'b0, 2'h0});
      n0 = rst_cnt;
      u_supply_pin_model.dip(0, 15);
      fork
         u_supply_pin_model.dip(1, 10);
         begin
            repeat (4) @(posedge pclk);
            chk("gpio in", 0, pin_gpio_in);
         end
      join
      repeat (6) @(posedge pclk);
      chk("ignored", n0, rst_cnt);
      chk("gpio in", 1, pin_gpio_in);
      apb(1, 12'h000, 32'h2);
      chk("sw pullup", 1, pin_pullup_en);
      apb(1, 12'h000, 32'h1);
      chk("sw pullup", 0, pin_pullup_en);
      restart('{brownout_nslp, 2'h0, 1'b1, 1'b0, 2'h0});
      sleep_mode <= 1'b1;
      wake_req <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("sleep monitor", 0, brownout_monitor_en);
      chk("wake free", 0, wake_hold);
      fork
         u_supply_pin_model.dip(0, 4);
         begin
            repeat (3) @(posedge pclk);
            chk("wake held", 1, wake_hold);
         end
      join
      repeat (3) @(posedge pclk);
      chk("wake free", 0, wake_hold);
      {sleep_mode, wake_req} <= 2'b00;
      $display("modes done");
      end_of_test();
   end
endmodule // tb_top
